/* File: core/sysctl_pkg.sv */
/*
 * Package for the system-control register bank: offsets, reset values,
 * identification field positions, interrupt bit layout and the request carrier.
 * Assumes a 32-bit byte-addressed register port on a single clock.
 */
package sysctl_pkg;

	// ==========================================================
	// Bank placement and register offsets (byte addresses)
	// ==========================================================
	localparam logic [31:0] BANK_BASE         = 32'h400FE000;
	localparam int          OFF_W             = 12;
	localparam logic [11:0] OFF_IDENTITY_0    = 12'h000;
	localparam logic [11:0] OFF_IDENTITY_1    = 12'h004;
	localparam logic [11:0] OFF_CAPABILITY_0  = 12'h008;
	localparam logic [11:0] OFF_CAPABILITY_1  = 12'h010;
	localparam logic [11:0] OFF_CAPABILITY_2  = 12'h014;
	localparam logic [11:0] OFF_CAPABILITY_3  = 12'h018;
	localparam logic [11:0] OFF_CAPABILITY_4  = 12'h01C;
	localparam logic [11:0] OFF_POR_BROWNOUT  = 12'h030;
	localparam logic [11:0] OFF_REG_POWER     = 12'h034;
	localparam logic [11:0] OFF_SOFT_RESET_0  = 12'h040;
	localparam logic [11:0] OFF_SOFT_RESET_1  = 12'h044;
	localparam logic [11:0] OFF_SOFT_RESET_2  = 12'h048;
	localparam logic [11:0] OFF_RAW_IRQ       = 12'h050;
	localparam logic [11:0] OFF_IRQ_MASK      = 12'h054;
	localparam logic [11:0] OFF_MASKED_IRQ    = 12'h058;
	localparam logic [11:0] OFF_RESET_CAUSE   = 12'h05C;
	localparam logic [11:0] OFF_RUN_CLOCK     = 12'h060;
	localparam logic [11:0] OFF_PLL_XLATE     = 12'h064;
	localparam logic [11:0] OFF_RUN_GATE_0    = 12'h100;
	localparam logic [11:0] OFF_RUN_GATE_1    = 12'h104;
	localparam logic [11:0] OFF_RUN_GATE_2    = 12'h108;
	localparam logic [11:0] OFF_SLEEP_GATE_0  = 12'h110;
	localparam logic [11:0] OFF_SLEEP_GATE_1  = 12'h114;
	localparam logic [11:0] OFF_SLEEP_GATE_2  = 12'h118;
	localparam logic [11:0] OFF_DEEP_GATE_0   = 12'h120;
	localparam logic [11:0] OFF_DEEP_GATE_1   = 12'h124;
	localparam logic [11:0] OFF_DEEP_GATE_2   = 12'h128;
	localparam logic [11:0] OFF_DEEP_CLK_CFG  = 12'h144;
	localparam logic [11:0] OFF_CLOCK_CLEAR   = 12'h150;
	localparam logic [11:0] OFF_REG_RST_ALLOW = 12'h160;

	// ==========================================================
	// Fixed and reset values
	// ==========================================================
	localparam logic [31:0] CAPABILITY_0_VAL  = 32'h001F001F;
	localparam logic [31:0] CAPABILITY_1_VAL  = 32'h00000003;
	localparam logic [31:0] CAPABILITY_2_VAL  = 32'h01071013;
	localparam logic [31:0] CAPABILITY_3_VAL  = 32'h3F0F01FF;
	localparam logic [31:0] CAPABILITY_4_VAL  = 32'h0000001F;
	localparam logic [31:0] POR_BROWNOUT_RST  = 32'h00007FFD;
	localparam logic [31:0] SLEEP_GATE_0_RST  = 32'h00000001;
	localparam logic [31:0] RUN_CLOCK_RST     = 32'h078E3AC0;
	localparam logic [31:0] DEEP_CLK_CFG_RST  = 32'h07800000;
	localparam logic [31:0] ZERO_WORD         = 32'h00000000;

	// ==========================================================
	// Identification word 0 field positions
	// ==========================================================
	localparam int ID_LAYOUT_MSB = 30;
	localparam int ID_LAYOUT_LSB = 28;
	localparam int ID_MAJOR_MSB  = 15;
	localparam int ID_MAJOR_LSB  = 8;
	localparam int ID_MINOR_MSB  = 7;
	localparam int ID_MINOR_LSB  = 0;

	// ==========================================================
	// Interrupt bit layout (status, mask, masked status share it)
	// ==========================================================
	localparam int IRQ_BROWNOUT  = 1;
	localparam int IRQ_REG_FAULT = 5;
	localparam int IRQ_PLL_LOCK  = 6;
	localparam int IRQ_CLK_FAIL  = 7;
	localparam logic [31:0] IRQ_IMPL_MASK = 32'h000000E2;

	// Register port request carrier
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

endpackage

/* File: core/sysctl_regs.sv */
/*
 * System-control register bank: identification, capability, reset control,
 * interrupt status/mask/clear, clock configuration and gating registers.
 * Assumes a plain single-cycle register port on clk, read data one cycle
 * after the read strobe, and event pulses synchronous to clk.
 */
`timescale 1ns/10ps

module sysctl_regs
	import sysctl_pkg::*;
#(
	parameter logic [2:0]  ID_LAYOUT  = 3'h1,   // Arbitrary layout code
	parameter logic [7:0]  ID_MAJOR   = 8'h01,  // Arbitrary revision value
	parameter logic [7:0]  ID_MINOR   = 8'h02,  // Arbitrary revision value
	parameter logic [31:0] IDENTITY_1 = 32'h10AB00E5 // Arbitrary part identity
) (
	input  wire logic              clk,            // System clock, 25 MHz
	input  wire logic              sys_rst,        // Async reset, active high
	input  wire sysctl_pkg::reg_req_t req,         // Register request
	output logic [31:0]            rdata,          // Read data, cycle after strobe
	input  wire logic              brownout_evt,   // Brown-out event pulse
	input  wire logic              reg_fault_evt,  // Regulator fault event pulse
	input  wire logic              pll_lock_evt,   // PLL lock event pulse
	input  wire logic              clk_fail_evt,   // Clock-check failure pulse
	input  wire logic [5:0]        reset_cause_in, // Reset cause flags, pulses
	output logic                   irq,            // Level interrupt request
	output logic                   clk_fail_hold,  // Failure latched until cleared
	output logic [31:0]            soft_reset_0,   // Soft reset lines word 0
	output logic [31:0]            soft_reset_1,   // Soft reset lines word 1
	output logic [31:0]            soft_reset_2,   // Soft reset lines word 2
	output logic [31:0]            run_clock_cfg,  // Run clock configuration
	output logic [31:0]            run_gate_0,     // Run gating word 0
	output logic [31:0]            run_gate_1,     // Run gating word 1
	output logic [31:0]            run_gate_2,     // Run gating word 2
	output logic                   reg_rst_allow   // Unregulated reset permitted
);
	import sysctl_pkg::*;

	// ==========================================================
	// Storage
	// ==========================================================
	logic [31:0] por_brownout_ff;
	logic [31:0] reg_power_ff;
	logic [31:0] soft_rst_ff [3];
	logic [31:0] raw_irq_ff;
	logic [31:0] irq_mask_ff;
	logic [31:0] reset_cause_ff;
	logic [31:0] run_clock_ff;
	logic [31:0] run_gate_ff [3];
	logic [31:0] sleep_gate_ff [3];
	logic [31:0] deep_gate_ff [3];
	logic [31:0] deep_clk_ff;
	logic [31:0] clock_clear_ff;
	logic [31:0] reg_rst_allow_ff;
	logic        clk_fail_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] masked_irq;
	logic [31:0] irq_events;
	logic [31:0] identity_0;
	logic [31:0] gate_mask [3];
	logic        wr_ok;
	logic [1:0]  gate_idx;

	// Full-word access only: an unaligned write must not alias a register
	assign wr_ok    = req.wr && (req.addr[1:0] == 2'h0);
	assign gate_idx = req.addr[3:2];

	// Capability words gate which clock bits can ever be set
	assign gate_mask[0] = CAPABILITY_1_VAL;
	assign gate_mask[1] = CAPABILITY_2_VAL;
	assign gate_mask[2] = CAPABILITY_4_VAL;

	// Reserved bits read as zero, a legal choice for indeterminate fields
	assign identity_0 = {1'h0, ID_LAYOUT, 12'h000, ID_MAJOR, ID_MINOR};

	// ==========================================================
	// Interrupt status
	// ==========================================================
	assign irq_events = (32'(brownout_evt) << IRQ_BROWNOUT)
		| (32'(reg_fault_evt) << IRQ_REG_FAULT)
		| (32'(pll_lock_evt) << IRQ_PLL_LOCK)
		| (32'(clk_fail_evt) << IRQ_CLK_FAIL);

	assign masked_irq = raw_irq_ff & irq_mask_ff;
	assign irq        = |masked_irq;

	// Sticky raw status; a new event beats a simultaneous clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			raw_irq_ff <= ZERO_WORD;
		end else begin
			if (wr_ok && req.addr == OFF_MASKED_IRQ) begin
				raw_irq_ff <= ((raw_irq_ff & ~req.wdata) | irq_events) & IRQ_IMPL_MASK;
			end else begin
				raw_irq_ff <= (raw_irq_ff | irq_events) & IRQ_IMPL_MASK;
			end
		end
	end

	// Mask register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_mask_ff <= ZERO_WORD;
		end else if (wr_ok && req.addr == OFF_IRQ_MASK) begin
			irq_mask_ff <= req.wdata & IRQ_IMPL_MASK;
		end
	end

	// ==========================================================
	// Clock-check failure hold
	// ==========================================================
	// Only a clear write or reset releases it; a fresh failure wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_fail_ff <= 1'b0;
		end else if (clk_fail_evt) begin
			clk_fail_ff <= 1'b1;
		end else if (wr_ok && req.addr == OFF_CLOCK_CLEAR && req.wdata[0]) begin
			clk_fail_ff <= 1'b0;
		end
	end
	assign clk_fail_hold = clk_fail_ff;

	// ==========================================================
	// Control registers
	// ==========================================================
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			por_brownout_ff  <= POR_BROWNOUT_RST;
			reg_power_ff     <= ZERO_WORD;
			run_clock_ff     <= RUN_CLOCK_RST;
			deep_clk_ff      <= DEEP_CLK_CFG_RST;
			clock_clear_ff   <= ZERO_WORD;
			reg_rst_allow_ff <= ZERO_WORD;
		end else if (wr_ok) begin
			unique case (req.addr)
				OFF_POR_BROWNOUT:  por_brownout_ff  <= req.wdata;
				OFF_REG_POWER:     reg_power_ff     <= req.wdata;
				OFF_RUN_CLOCK:     run_clock_ff     <= req.wdata;
				OFF_DEEP_CLK_CFG:  deep_clk_ff      <= req.wdata;
				OFF_CLOCK_CLEAR:   clock_clear_ff   <= req.wdata;
				OFF_REG_RST_ALLOW: reg_rst_allow_ff <= req.wdata;
				default: ;
			endcase
		end
	end

	// Reset cause flags accumulate until software overwrites them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reset_cause_ff <= ZERO_WORD;
		end else if (wr_ok && req.addr == OFF_RESET_CAUSE) begin
			reset_cause_ff <= req.wdata | 32'(reset_cause_in);
		end else begin
			reset_cause_ff <= reset_cause_ff | 32'(reset_cause_in);
		end
	end

	// Soft reset registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 3; i++) begin
				soft_rst_ff[i] <= ZERO_WORD;
			end
		end else if (wr_ok && req.addr[11:4] == OFF_SOFT_RESET_0[11:4] && gate_idx != 2'h3) begin
			soft_rst_ff[gate_idx] <= req.wdata;
		end
	end

	// Gating registers, writes filtered by capability masks
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 3; i++) begin
				run_gate_ff[i]   <= ZERO_WORD;
				sleep_gate_ff[i] <= (i == 0) ? SLEEP_GATE_0_RST : ZERO_WORD;
				deep_gate_ff[i]  <= (i == 0) ? SLEEP_GATE_0_RST : ZERO_WORD;
			end
		end else if (wr_ok && gate_idx != 2'h3) begin
			if (req.addr[11:4] == OFF_RUN_GATE_0[11:4]) begin
				run_gate_ff[gate_idx] <= req.wdata & gate_mask[gate_idx];
			end
			if (req.addr[11:4] == OFF_SLEEP_GATE_0[11:4]) begin
				sleep_gate_ff[gate_idx] <= req.wdata & gate_mask[gate_idx];
			end
			if (req.addr[11:4] == OFF_DEEP_GATE_0[11:4]) begin
				deep_gate_ff[gate_idx] <= req.wdata & gate_mask[gate_idx];
			end
		end
	end

	// ==========================================================
	// Read path
	// ==========================================================
	// Read-only words have no write case above, so writes fall away
	always_comb begin
		nxt_rdata = ZERO_WORD;
		unique case (req.addr)
			OFF_IDENTITY_0:    nxt_rdata = identity_0;
			OFF_IDENTITY_1:    nxt_rdata = IDENTITY_1;
			OFF_CAPABILITY_0:  nxt_rdata = CAPABILITY_0_VAL;
			OFF_CAPABILITY_1:  nxt_rdata = CAPABILITY_1_VAL;
			OFF_CAPABILITY_2:  nxt_rdata = CAPABILITY_2_VAL;
			OFF_CAPABILITY_3:  nxt_rdata = CAPABILITY_3_VAL;
			OFF_CAPABILITY_4:  nxt_rdata = CAPABILITY_4_VAL;
			OFF_POR_BROWNOUT:  nxt_rdata = por_brownout_ff;
			OFF_REG_POWER:     nxt_rdata = reg_power_ff;
			OFF_SOFT_RESET_0:  nxt_rdata = soft_rst_ff[0];
			OFF_SOFT_RESET_1:  nxt_rdata = soft_rst_ff[1];
			OFF_SOFT_RESET_2:  nxt_rdata = soft_rst_ff[2];
			OFF_RAW_IRQ:       nxt_rdata = raw_irq_ff;
			OFF_IRQ_MASK:      nxt_rdata = irq_mask_ff;
			OFF_MASKED_IRQ:    nxt_rdata = masked_irq;
			OFF_RESET_CAUSE:   nxt_rdata = reset_cause_ff;
			OFF_RUN_CLOCK:     nxt_rdata = run_clock_ff;
			OFF_PLL_XLATE:     nxt_rdata = ZERO_WORD;
			OFF_RUN_GATE_0:    nxt_rdata = run_gate_ff[0];
			OFF_RUN_GATE_1:    nxt_rdata = run_gate_ff[1];
			OFF_RUN_GATE_2:    nxt_rdata = run_gate_ff[2];
			OFF_SLEEP_GATE_0:  nxt_rdata = sleep_gate_ff[0];
			OFF_SLEEP_GATE_1:  nxt_rdata = sleep_gate_ff[1];
			OFF_SLEEP_GATE_2:  nxt_rdata = sleep_gate_ff[2];
			OFF_DEEP_GATE_0:   nxt_rdata = deep_gate_ff[0];
			OFF_DEEP_GATE_1:   nxt_rdata = deep_gate_ff[1];
			OFF_DEEP_GATE_2:   nxt_rdata = deep_gate_ff[2];
			OFF_DEEP_CLK_CFG:  nxt_rdata = deep_clk_ff;
			OFF_CLOCK_CLEAR:   nxt_rdata = clock_clear_ff;
			OFF_REG_RST_ALLOW: nxt_rdata = reg_rst_allow_ff;
			default:           nxt_rdata = ZERO_WORD;
		endcase
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_ff <= ZERO_WORD;
		end else if (req.rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= ZERO_WORD;
		end
	end

	assign rdata         = rdata_ff;
	assign soft_reset_0  = soft_rst_ff[0];
	assign soft_reset_1  = soft_rst_ff[1];
	assign soft_reset_2  = soft_rst_ff[2];
	assign run_clock_cfg = run_clock_ff;
	assign run_gate_0    = run_gate_ff[0];
	assign run_gate_1    = run_gate_ff[1];
	assign run_gate_2    = run_gate_ff[2];
	assign reg_rst_allow = reg_rst_allow_ff[0];

endmodule

/* File: testbench/sysctl_regs_checker.sv */
/*
 * Port-level assertions for the system-control register bank.
 * Assumes the master never raises both strobes in one cycle.
 */
`timescale 1ns/10ps

module sysctl_regs_checker
	import sysctl_pkg::*;
#(
	parameter logic [2:0] ID_LAYOUT = 3'h1,  // Follows the design
	parameter logic [7:0] ID_MAJOR  = 8'h01, // Follows the design
	parameter logic [7:0] ID_MINOR  = 8'h02  // Follows the design
) (
	input wire logic                 clk,           // System clock
	input wire logic                 sys_rst,       // Async reset
	input wire sysctl_pkg::reg_req_t req,           // Register request
	input wire logic [31:0]          rdata,         // Read data
	input wire logic                 clk_fail_evt,  // Clock failure pulse
	input wire logic                 irq,           // Interrupt level
	input wire logic                 clk_fail_hold, // Failure latch
	input wire logic [31:0]          soft_reset_0,  // Soft reset word 0
	input wire logic [31:0]          run_gate_0,    // Run gating word 0
	input wire logic                 reg_rst_allow  // Regulator reset allow
);
	// ==========================================================
	// Bus read behaviour
	// ==========================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Stale data on the bus would hide decode faults
	chk_rdata_idle: assert property (
		!$past(req.rd) |-> rdata == 32'h00000000)
		else $error("Read data not zero outside the read slot");
	chk_cap0_read: assert property (
		req.rd && req.addr == OFF_CAPABILITY_0 |=> rdata == 32'h001F001F)
		else $error("Capability word 0 wrong");
	chk_cap1_read: assert property (
		req.rd && req.addr == OFF_CAPABILITY_1 |=> rdata == 32'h00000003)
		else $error("Capability word 1 wrong");
	chk_id_fields: assert property (
		req.rd && req.addr == OFF_IDENTITY_0
		|=> rdata[30:28] == ID_LAYOUT && rdata[15:0] == {ID_MAJOR, ID_MINOR})
		else $error("Identity word 0 fields wrong");
	chk_masked_read: assert property (
		req.rd && req.addr == OFF_MASKED_IRQ |=> (rdata != 32'h00000000) == $past(irq))
		else $error("Masked status disagrees with interrupt line");

	// ==========================================================
	// Register updates and latched failure
	// ==========================================================
	chk_fail_sets: assert property (
		clk_fail_evt |=> clk_fail_hold)
		else $error("Clock failure not latched");
	chk_fail_holds: assert property (
		clk_fail_hold && !(req.wr && req.addr == OFF_CLOCK_CLEAR) |=> clk_fail_hold)
		else $error("Clock failure dropped without clear");
	chk_soft_write: assert property (
		req.wr && req.addr == OFF_SOFT_RESET_0 |=> soft_reset_0 == $past(req.wdata))
		else $error("Soft reset word 0 not written");
	chk_gate_mask: assert property (
		req.wr && req.addr == OFF_RUN_GATE_0
		|=> run_gate_0 == ($past(req.wdata) & 32'h00000003))
		else $error("Run gating word 0 not masked");
	chk_allow_write: assert property (
		req.wr && req.addr == OFF_REG_RST_ALLOW |=> reg_rst_allow == $past(req.wdata[0]))
		else $error("Regulator reset allow not written");
endmodule

bind sysctl_regs sysctl_regs_checker #(
	.ID_LAYOUT(ID_LAYOUT),
	.ID_MAJOR (ID_MAJOR),
	.ID_MINOR (ID_MINOR)
) chk_i (
	.clk          (clk),
	.sys_rst      (sys_rst),
	.req          (req),
	.rdata        (rdata),
	.clk_fail_evt (clk_fail_evt),
	.irq          (irq),
	.clk_fail_hold(clk_fail_hold),
	.soft_reset_0 (soft_reset_0),
	.run_gate_0   (run_gate_0),
	.reg_rst_allow(reg_rst_allow)
);

/* File: testbench/sysctl_regs_tb.sv */
/*
 * Self-checking bench for the register bank: a table of accesses, then
 * reset values and interrupt handling. Assumes the checker binds itself.
 */
`timescale 1ns/10ps

module sysctl_regs_tb;
	import sysctl_pkg::*;
	typedef struct {logic [11:0] addr; logic wr; logic [31:0] wdata; logic [31:0] exp;} row_t;
	localparam logic [31:0] ID1 = 32'h5A5A0001; // Arbitrary identity value
	logic        clk, sys_rst, irq, clk_fail_hold, reg_rst_allow;
	logic [3:0]  evts;
	logic [5:0]  cause;
	logic [31:0] soft_reset_1, soft_reset_2, run_clock_cfg, run_gate_1, run_gate_2;
	reg_req_t    req;
	logic [31:0] rdata, soft_reset_0, run_gate_0, seen;
	int          bad_count, total_checks;
	// Writes to read-only and unmapped places must change nothing
	row_t rows [18] = '{
		'{OFF_SOFT_RESET_0, 1'h1, 32'hA5A5A5A5, 32'hA5A5A5A5},
		'{OFF_SOFT_RESET_1, 1'h1, 32'h12345678, 32'h12345678},
		'{OFF_SOFT_RESET_2, 1'h1, 32'hFFFFFFFF, 32'hFFFFFFFF},
		'{OFF_IDENTITY_0, 1'h1, 32'h00000000, 32'h20000307},
		'{OFF_IDENTITY_1, 1'h1, 32'h00000000, ID1},
		'{OFF_CAPABILITY_0, 1'h1, 32'h00000000, 32'h001F001F},
		'{OFF_CAPABILITY_1, 1'h1, 32'hFFFFFFFF, 32'h00000003},
		'{OFF_CAPABILITY_2, 1'h0, 32'h00000000, 32'h01071013},
		'{OFF_CAPABILITY_3, 1'h0, 32'h00000000, 32'h3F0F01FF},
		'{OFF_CAPABILITY_4, 1'h1, 32'h00000000, 32'h0000001F},
		'{OFF_RUN_GATE_0, 1'h1, 32'hFFFFFFFF, 32'h00000003},
		'{12'h104, 1'h1, 32'hFFFFFFFF, 32'h01071013},
		'{12'h108, 1'h1, 32'hFFFFFFFF, 32'h0000001F},
		'{12'h124, 1'h1, 32'hFFFFFFFF, 32'h01071013},
		'{OFF_REG_RST_ALLOW, 1'h1, 32'h00000001, 32'h00000001},
		'{OFF_RUN_CLOCK, 1'h1, 32'h0ACE1234, 32'h0ACE1234},
		'{12'h0F0, 1'h1, 32'hFFFFFFFF, 32'h00000000},
		'{OFF_PLL_XLATE, 1'h1, 32'hFFFFFFFF, 32'h00000000}};
	row_t rst_rows [10] = '{
		'{OFF_POR_BROWNOUT, 1'h0, 32'h0, 32'h00007FFD},
		'{OFF_SOFT_RESET_0, 1'h0, 32'h0, 32'h00000000},
		'{OFF_SOFT_RESET_1, 1'h0, 32'h0, 32'h00000000},
		'{OFF_SOFT_RESET_2, 1'h0, 32'h0, 32'h00000000},
		'{OFF_SLEEP_GATE_0, 1'h0, 32'h0, 32'h00000001},
		'{OFF_DEEP_GATE_0, 1'h0, 32'h0, 32'h00000001},
		'{12'h114, 1'h0, 32'h0, 32'h00000000},
		'{OFF_REG_RST_ALLOW, 1'h0, 32'h0, 32'h00000000},
		'{OFF_RUN_CLOCK, 1'h0, 32'h0, 32'h078E3AC0},
		'{OFF_IRQ_MASK, 1'h0, 32'h0, 32'h00000000}};

	sysctl_regs #(.ID_LAYOUT(3'h2), .ID_MAJOR(8'h03), .ID_MINOR(8'h07), .IDENTITY_1(ID1)) dut (
		.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
		.brownout_evt(evts[3]), .reg_fault_evt(evts[2]), .pll_lock_evt(evts[1]),
		.clk_fail_evt(evts[0]), .reset_cause_in(cause), .irq(irq),
		.clk_fail_hold(clk_fail_hold), .soft_reset_0(soft_reset_0),
		.soft_reset_1(soft_reset_1), .soft_reset_2(soft_reset_2),
		.run_clock_cfg(run_clock_cfg), .run_gate_0(run_gate_0), .run_gate_1(run_gate_1),
		.run_gate_2(run_gate_2), .reg_rst_allow(reg_rst_allow));

	// ==========================================================
	// Bus and checking tasks
	// ==========================================================
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Tasks end 1 ns after the edge so results have settled
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk);
		req.wr <= 1'h0;
		#1;
	endtask
	task automatic rd_reg(input logic [11:0] a);
		@(posedge clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
		@(posedge clk);
		req.rd <= 1'h0;
		#1 seen = rdata;
	endtask
	task automatic access(input row_t r);
		if (r.wr)
			wr_reg(r.addr, r.wdata);
		rd_reg(r.addr);
		check("register read", seen, r.exp);
	endtask
	// Write and event land on one edge; the event must win
	task automatic wr_evt(input logic [11:0] a, input logic [31:0] d, input logic [3:0] ev);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		evts <= ev;
		@(posedge clk);
		req.wr <= 1'h0;
		evts <= 4'h0;
		#1;
	endtask
	task automatic pulse(input logic [3:0] ev);
		@(posedge clk);
		evts <= ev;
		@(posedge clk);
		evts <= 4'h0;
		#1;
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	// ==========================================================
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	// No wait is open-ended, but a hang still ends in the report
	initial begin
		#400000;
		bad_count++;
		test_done;
	end
	initial begin
		sys_rst = 1'h1;
		req = '0;
		evts = 4'h0;
		cause = 6'h00;
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		foreach (rows[i]) access(rows[i]);
		check("soft_reset_0 port", soft_reset_0, 32'hA5A5A5A5);
		check("run_gate_0 port", run_gate_0, 32'h00000003);
		check("reg_rst_allow port", {31'h0, reg_rst_allow}, 32'h1);
		check("soft_reset_1 port", soft_reset_1, 32'h12345678);
		check("soft_reset_2 port", soft_reset_2, 32'hFFFFFFFF);
		check("run_gate_1 port", run_gate_1, 32'h01071013);
		check("run_gate_2 port", run_gate_2, 32'h0000001F);
		check("run_clock_cfg port", run_clock_cfg, 32'h0ACE1234);
		// Second reset in mid-run, then reset values
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		foreach (rst_rows[i]) access(rst_rows[i]);
		check("soft_reset_0 after reset", soft_reset_0, 32'h0);
		check("soft_reset_2 after reset", soft_reset_2, 32'h0);
		check("run_gate_1 after reset", run_gate_1, 32'h0);
		check("run_clock_cfg after reset", run_clock_cfg, 32'h078E3AC0);
		// Unmasked clock failure, masked PLL lock, W1C and clear
		wr_reg(OFF_IRQ_MASK, 32'h00000080);
		pulse(4'h1);
		check("irq on failure", {31'h0, irq}, 32'h1);
		check("failure latch", {31'h0, clk_fail_hold}, 32'h1);
		pulse(4'h2);
		rd_reg(OFF_MASKED_IRQ);
		check("masked status", seen, 32'h00000080);
		rd_reg(OFF_RAW_IRQ);
		check("raw status", seen, 32'h000000C0);
		wr_reg(OFF_MASKED_IRQ, 32'h00000080);
		check("irq after clear", {31'h0, irq}, 32'h0);
		check("latch after status clear", {31'h0, clk_fail_hold}, 32'h1);
		rd_reg(OFF_RAW_IRQ);
		check("raw after clear", seen, 32'h00000040);
		wr_reg(OFF_CLOCK_CLEAR, 32'h00000001);
		check("latch after clear", {31'h0, clk_fail_hold}, 32'h0);
		wr_reg(OFF_IRQ_MASK, 32'h00000022);
		pulse(4'hC);
		check("irq on brown-out", {31'h0, irq}, 32'h1);
		rd_reg(OFF_MASKED_IRQ);
		check("masked pair", seen, 32'h00000022);
		wr_reg(OFF_MASKED_IRQ, 32'hFFFFFFFF);
		rd_reg(OFF_RAW_IRQ);
		check("raw all cleared", seen, 32'h0);
		check("irq all cleared", {31'h0, irq}, 32'h0);
		// Clear racing a fresh failure: the set wins in both places
		wr_reg(OFF_IRQ_MASK, 32'h00000080);
		wr_evt(OFF_MASKED_IRQ, 32'h00000080, 4'h1);
		check("irq set beats clear", {31'h0, irq}, 32'h1);
		wr_evt(OFF_CLOCK_CLEAR, 32'h00000001, 4'h1);
		check("latch set beats clear", {31'h0, clk_fail_hold}, 32'h1);
		rd_reg(OFF_RAW_IRQ);
		check("raw set beats clear", seen, 32'h00000080);
		// Reset causes gather until software overwrites them
		@(posedge clk);
		cause <= 6'h05;
		@(posedge clk);
		cause <= 6'h00;
		rd_reg(OFF_RESET_CAUSE);
		check("reset cause gathered", seen, 32'h00000005);
		wr_reg(OFF_RESET_CAUSE, 32'h00000000);
		rd_reg(OFF_RESET_CAUSE);
		check("reset cause replaced", seen, 32'h00000000);
		test_done;
	end
endmodule
